/* dv/spto_asserts.sv */
// Port-level assertions for the SPI transfer block
`timescale 1ns/10ps
`default_nettype none
module spto_asserts (
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic [7:0]  s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        ss_n_i,
  input wire logic        ss_n_o,
  input wire logic        sck_o,
  input wire logic        sck_oe_n_o,
  input wire logic        miso_oe_n_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Long enough to cover the input synchroniser and the output register
  sequence ss_idle_s; ss_n_i [*8]; endsequence
  sequence sck_high_s; sck_o [*3]; endsequence
  miso_rel_a: assert property (ss_idle_s |-> miso_oe_n_o)
    else $error("data out driven while deselected");
  ss_sync_a: assert property (ss_idle_s ##1 !ss_n_i |-> miso_oe_n_o ##1 miso_oe_n_o)
    else $error("select seen before synchroniser");
  sck_frame_a: assert property (!sck_oe_n_o && $changed(sck_o) |-> !ss_n_o)
    else $error("clock toggled with select high");
  sck_half_a: assert property ($rose(sck_o) && !sck_oe_n_o |=> sck_high_s)
    else $error("clock high phase too short");
  aw_pulse_a: assert property (s_axi_awready_o |=> !s_axi_awready_o)
    else $error("write address ready longer than one cycle");
  write_resp_a: assert property (s_axi_awvalid_i && s_axi_awready_o |-> ##[1:4] s_axi_bvalid_o)
    else $error("write response late");
  read_lat_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read data late");
  unmapped_rd_a: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == 8'h1c
    |=> s_axi_rresp_o == 2'b10 && s_axi_rdata_o == 32'h0000_0000)
    else $error("unmapped read not refused");
endmodule // spto_asserts
bind spto_top spto_asserts u_chk (
  .sys_clk_i, .reset_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_bvalid_o,
  .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
  .s_axi_rvalid_o, .ss_n_i, .ss_n_o, .sck_o, .sck_oe_n_o, .miso_oe_n_o
);
`default_nettype wire

/* dv/spto_far_end.sv */
// Remote SPI master model, mode 0, MSB first; echoes data out as a far slave
`timescale 1ns/10ps
`default_nettype none
module spto_far_end (
  input  wire logic mosi_w_i,
  input  wire logic miso_i,
  output var  logic sck_o,
  output var  logic ss_n_o,
  output var  logic mosi_o,
  output wire logic miso_o
);
  // When the block is master this side answers with what it hears
  assign miso_o = mosi_w_i;
  initial begin
    sck_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  task automatic xfer(input logic [7:0] tx, input bit last, output logic [7:0] rx);
    ss_n_o = 1'b0;
    #62.5;
    for (int i = 7; i >= 0; i--) begin
      mosi_o = tx[i];
      #62.5 sck_o = 1'b1;
      rx[i] = miso_i;
      #62.5 sck_o = 1'b0;
    end
    // Released line must not keep a stale copy
    mosi_o = ~mosi_o;
    if (last) begin
      #62.5 ss_n_o = 1'b1;
      #62.5;
    end
  endtask
endmodule // spto_far_end
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the SPI transfer block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        sys_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [7:0]  s_axi_awaddr_i = 8'h00;
  logic [7:0]  s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb_i = 4'hf;
  logic        s_axi_awvalid_i = 1'b0;
  logic        s_axi_wvalid_i = 1'b0;
  logic        s_axi_bready_i = 1'b0;
  logic        s_axi_arvalid_i = 1'b0;
  logic        s_axi_rready_i = 1'b0;
  wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  wire         s_axi_rvalid_o, irq_o, p_sck, p_ss_n, p_mosi, p_miso;
  wire [1:0]   s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0]  s_axi_rdata_o;
  wire         sck_o, sck_oe_n_o, ss_n_o, ss_oe_n_o, mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o;
  wire         sck_i = sck_oe_n_o ? p_sck : sck_o;
  wire         ss_n_i = ss_oe_n_o ? p_ss_n : ss_n_o;
  wire         mosi_i = mosi_oe_n_o ? p_mosi : mosi_o;
  wire         miso_i = miso_oe_n_o ? p_miso : miso_o;
  int          fails = 0;
  int          comparisons = 0;
  logic [31:0] last_rd;
  spto_top uut (
    .sys_clk_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .sck_i, .sck_o,
    .sck_oe_n_o, .ss_n_i, .ss_n_o, .ss_oe_n_o, .mosi_i, .mosi_o, .mosi_oe_n_o, .miso_i,
    .miso_o, .miso_oe_n_o, .irq_o
  );
  spto_far_end far (.mosi_w_i(mosi_i), .miso_i(miso_i), .sck_o(p_sck), .ss_n_o(p_ss_n),
    .mosi_o(p_mosi), .miso_o(p_miso));
  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] a, input logic [33:0] g, input logic [33:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("wrong value item %h expected %h seen %h", a, e, g);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 40) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {16'h0000, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      n++;
    end while (s_axi_bvalid_o !== 1'b1 && n < 40);
    s_axi_bready_i <= 1'b0;
    guard(n);
  endtask
  // A zero mask reads without comparing
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                        input logic [1:0] er = 2'b00);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      n++;
    end while (s_axi_rvalid_o !== 1'b1 && n < 40);
    s_axi_rready_i <= 1'b0;
    guard(n);
    last_rd = s_axi_rdata_o;
    if (m != 8'h00)
      check(a, {s_axi_rresp_o, s_axi_rdata_o & {24'hff_ffff, m}}, {er, 24'h00_0000, e});
  endtask
  task automatic t_reset();
    rd_chk(8'h00, 8'hff, 8'h00);
    rd_chk(8'h0c, 8'hff, 8'h01);
    rd_chk(8'h04, 8'hff, 8'h00);
    rd_chk(8'h1c, 8'hff, 8'h00, 2'b10);
    check(8'hff, {33'h0, irq_o}, 34'h0);
  endtask
  task automatic t_slave();
    logic [7:0] r0, r1;
    wr(8'h00, 16'h0041);
    wr(8'h10, 16'h0002);
    // data written while empty flag set
    wr(8'h08, 16'h00c3);
    far.xfer(8'h3c, 1'b0, r0);
    far.xfer(8'h96, 1'b1, r1);
    check(8'hfc, {26'h0, r1}, {26'h0, 8'hc3});
    rd_chk(8'h0c, 8'h06, 8'h06);
    check(8'hff, {33'h0, irq_o}, 34'h1);
    rd_chk(8'h08, 8'hff, 8'h3c);
    rd_chk(8'h08, 8'hff, 8'h96);
    rd_chk(8'h0c, 8'h05, 8'h01);
    wr(8'h14, 16'h0002);
    rd_chk(8'h0c, 8'h02, 8'h00);
    check(8'hfe, {33'h0, irq_o}, 34'h0);
    wr(8'h10, 16'h0000);
    far.xfer(8'h00, 1'b1, r0);
    check(8'hfd, {33'h0, irq_o}, 34'h0);
    rd_chk(8'h08, 8'hff, 8'h00);
  endtask
  task automatic t_ovf(input logic imm);
    logic [7:0] r;
    wr(8'h00, 16'h0041 | {14'h0000, imm, 1'b0});
    far.xfer(8'h11, 1'b1, r);
    far.xfer(8'h22, 1'b1, r);
    check(8'hfa, {26'h0, r}, {26'h0, 8'h11});
    far.xfer(8'h33, 1'b1, r);
    rd_chk(8'h04, 8'h01, {7'h00, imm});
    rd_chk(8'h08, 8'hff, 8'h11);
    rd_chk(8'h08, 8'hff, imm ? 8'h22 : 8'h00);
    rd_chk(8'h0c, 8'h08, imm ? 8'h00 : 8'h08);
    if (imm)
      rd_chk(8'h0c, 8'h04, 8'h00);
    rd_chk(8'h04, 8'h01, 8'h01);
    if (imm)
      wr(8'h00, 16'h0042);
    else
      wr(8'h04, 16'h0001);
    rd_chk(8'h04, 8'h01, 8'h00);
    wr(8'h14, 16'h000e);
  endtask
  task automatic t_addr();
    logic [7:0] r;
    wr(8'h18, 16'h0042);
    wr(8'h00, 16'h0241);
    far.xfer(8'h42, 1'b1, r);
    rd_chk(8'h0c, 8'h10, 8'h10);
    rd_chk(8'h08, 8'h00, 8'h00);
  endtask
  task automatic t_master();
    int n;
    n = 0;
    wr(8'h14, 16'h001f);
    wr(8'h00, 16'h0065);
    wr(8'h08, 16'h005a);
    do begin
      rd_chk(8'h0c, 8'h00, 8'h00);
      n++;
    end while (last_rd[2] !== 1'b1 && n < 40);
    guard(n);
    rd_chk(8'h0c, 8'h02, 8'h02);
    rd_chk(8'h08, 8'hff, 8'h5a);
    check(8'hfb, {33'h0, ss_n_o}, 34'h1);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_slave();
    t_ovf(1'b0);
    t_ovf(1'b1);
    t_addr();
    t_master();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire

/* hdl/spto_top.v */
// SPI transfer logic with two-entry receive buffer and AXI4-Lite registers
// Behaviour
// - Master sets receive complete after last bit; character readable from data.
// - Master sets transmit complete when shifter done and data register empty.
// - Master raises select at transaction end; software does it when auto off.
// - Slave mode idles with MISO released while select is high.
// - Slave samples and shifts per clock phase and polarity while selected.
// - Slave sets data register empty once pending data enters shifter.
// - Slave stores each character in two-entry buffer on last bit unless full, flags complete.
// - Slave sets transmit complete when master raises select.
// - Written value needs two link clock cycles before it can load in slave mode.
// - Late write makes slave resend the previously received character.
// - Data register empty flag asserts three bus cycles after emptying.
// - Overflow bit is sticky, cleared by writing one or disabling.
// - Immediate notification raises overflow at the moment it happens.
// - Otherwise overflow travels with data; flags set together, data reads zero.
// - Slave with address form compares first character against its address.
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "spto_consts.vh"
module spto_top (
  input  wire        sys_clk_i,
  input  wire        reset_n_i,
  input  wire [7:0]  s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output reg         s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output reg         s_axi_wready_o,
  output reg  [1:0]  s_axi_bresp_o,
  output reg         s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  input  wire [7:0]  s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output reg         s_axi_arready_o,
  output reg  [31:0] s_axi_rdata_o,
  output reg  [1:0]  s_axi_rresp_o,
  output reg         s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  input  wire        sck_i,
  output reg         sck_o,
  output reg         sck_oe_n_o,
  input  wire        ss_n_i,
  output reg         ss_n_o,
  output reg         ss_oe_n_o,
  input  wire        mosi_i,
  output reg         mosi_o,
  output reg         mosi_oe_n_o,
  input  wire        miso_i,
  output reg         miso_o,
  output reg         miso_oe_n_o,
  output reg         irq_o
);
  // Registers
  reg  [31:0] ctrl;
  reg  [7:0]  own_addr;
  reg  [4:0]  irq_en;
  reg  [4:0]  flags;
  reg         ovf;
  // Transmit holding value and its load pipeline
  reg  [7:0]  tx_hold;
  reg         tx_valid;
  reg  [1:0]  tx_age;
  reg  [1:0]  dre_cnt;
  // Receive buffer: two entries with overflow markers
  reg  [7:0]  rx_mem [0:1];
  reg  [1:0]  rx_ovm;
  reg         rx_wp;
  reg         rx_rp;
  reg  [1:0]  rx_cnt;
  // Shifter
  reg  [7:0]  sh_out;
  reg  [7:0]  sh_in;
  reg  [3:0]  bit_cnt;
  reg         first_char;
  reg         active;
  reg  [3:0]  div_cnt;
  // Synchronisers, three stages each
  reg  [2:0]  sck_s;
  reg  [2:0]  ss_s;
  reg  [2:0]  mosi_s;
  reg  [2:0]  miso_s;
  reg         sck_st;
  reg         ss_st;
  // AXI write capture
  reg         aw_hold;
  reg         w_hold;
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;

  wire        en        = ctrl[`SPTO_CTRL_ENABLE];
  wire        imm_ovf   = ctrl[`SPTO_CTRL_IMM_OVF];
  wire        auto_ss   = ctrl[`SPTO_CTRL_AUTO_SS];
  wire        cpha      = ctrl[`SPTO_CTRL_CPHA];
  wire        cpol      = ctrl[`SPTO_CTRL_CPOL];
  wire [1:0]  mode      = ctrl[`SPTO_CTRL_MODE_LO+1:`SPTO_CTRL_MODE_LO];
  wire [2:0]  form      = ctrl[`SPTO_CTRL_FORM_LO+2:`SPTO_CTRL_FORM_LO];
  wire        is_master = en && (mode == `SPTO_MODE_MASTER);
  wire        is_slave  = en && (mode == `SPTO_MODE_SLAVE);

  // Leading edge is the sample edge when phase is zero
  function sample_edge;
    input rise;
    input pol;
    input pha;
    begin
      sample_edge = (rise ^ pol) ^ pha;
    end
  endfunction

  wire        sck_new  = (sck_s[2] == sck_s[1]) ? sck_s[2] : sck_st;
  wire        ss_new   = (ss_s[2] == ss_s[1]) ? ss_s[2] : ss_st;
  wire        s_rise   = !sck_st && sck_new;
  wire        s_fall   = sck_st && !sck_new;
  wire        ss_high_edge = !ss_st && ss_new;

  // Master clock generation: sck toggles every divider wrap
  wire        m_tick   = (div_cnt == `SPTO_MASTER_DIV - 4'h1);
  wire        m_rise   = m_tick && (sck_o == cpol);
  wire        m_fall   = m_tick && (sck_o != cpol);
  // Clock finishes its last half period before select is raised
  wire        sck_run  = active || (is_master && sck_o != cpol);
  wire        do_rise  = is_master ? (active && m_rise) : (is_slave && !ss_st && s_rise);
  wire        do_fall  = is_master ? (active && m_fall) : (is_slave && !ss_st && s_fall);
  wire        smp      = sample_edge(1'b1, cpol, cpha) ? do_rise : do_fall;
  wire        shf      = sample_edge(1'b1, cpol, cpha) ? do_fall : do_rise;
  wire        rx_bit   = is_master ? miso_s[2] : mosi_s[2];
  wire [7:0]  rx_char  = {sh_in[6:0], rx_bit};
  wire        char_end = smp && (bit_cnt == 4'h7);
  wire        rx_full  = (rx_cnt == 2'h2);
  wire        rd_data  = s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == `SPTO_OFF_DATA;
  wire        rd_pop   = rd_data && (rx_cnt != 2'h0);
  wire        wr_go    = aw_hold && w_hold && !s_axi_bvalid_o;
  wire        wr_data  = wr_go && aw_addr == `SPTO_OFF_DATA;
  // in slave mode value may load only once it has aged two link cycles; master loads it at once
  wire        tx_ready = tx_valid && (tx_age == `SPTO_LOAD_MARGIN - 4'h1 || is_master);
  wire        load_now = (char_end || (!active && is_master)) && tx_ready;
  wire        head_ovm = rx_ovm[rx_rp];

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sck_s <= 3'h0; ss_s <= 3'h7; mosi_s <= 3'h0; miso_s <= 3'h0;
      sck_st <= 1'b0; ss_st <= 1'b1;
    end else begin
      sck_s  <= {sck_s[1:0], sck_i};
      ss_s   <= {ss_s[1:0], ss_n_i};
      mosi_s <= {mosi_s[1:0], mosi_i};
      miso_s <= {miso_s[1:0], miso_i};
      sck_st <= sck_new;
      ss_st  <= ss_new;
    end
  end

  // AXI4-Lite slave: address and data taken in either order
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      s_axi_awready_o <= 1'b0; s_axi_wready_o <= 1'b0; s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= 2'h0; s_axi_arready_o <= 1'b0; s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o <= 2'h0; s_axi_rdata_o <= 32'h0000_0000;
      aw_hold <= 1'b0; w_hold <= 1'b0; aw_addr <= 8'h00; w_data <= 32'h0000_0000;
    end else begin
      s_axi_awready_o <= !aw_hold && !s_axi_awready_o && s_axi_awvalid_i;
      s_axi_wready_o  <= !w_hold && !s_axi_wready_o && s_axi_wvalid_i;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_hold <= 1'b1; aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_hold <= 1'b1; w_data <= s_axi_wdata_i;
      end
      if (wr_go) begin
        aw_hold <= 1'b0; w_hold <= 1'b0; s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= (aw_addr > `SPTO_OFF_ADDR || aw_addr[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
      s_axi_arready_o <= !s_axi_arready_o && !s_axi_rvalid_o && s_axi_arvalid_i;
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o  <= 2'h0;
        if (s_axi_araddr_i == `SPTO_OFF_CTRL) begin
          s_axi_rdata_o <= ctrl;
        end else if (s_axi_araddr_i == `SPTO_OFF_STATUS) begin
          s_axi_rdata_o <= {30'h0000_0000, rx_cnt != 2'h0, ovf};
        end else if (s_axi_araddr_i == `SPTO_OFF_DATA) begin
          s_axi_rdata_o <= (rx_cnt == 2'h0 || head_ovm) ? 32'h0000_0000
                                                       : {24'h00_0000, rx_mem[rx_rp]};
        end else if (s_axi_araddr_i == `SPTO_OFF_FLAGS) begin
          s_axi_rdata_o <= {27'h000_0000, flags};
        end else if (s_axi_araddr_i == `SPTO_OFF_IRQ_EN) begin
          s_axi_rdata_o <= {27'h000_0000, irq_en};
        end else if (s_axi_araddr_i == `SPTO_OFF_IRQ_CLR) begin
          s_axi_rdata_o <= 32'h0000_0000;
        end else if (s_axi_araddr_i == `SPTO_OFF_ADDR) begin
          s_axi_rdata_o <= {24'h00_0000, own_addr};
        end else begin
          s_axi_rdata_o <= 32'h0000_0000;
          s_axi_rresp_o <= 2'h2;
        end
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // Control, transmit holding value and flag logic
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ctrl <= `SPTO_CTRL_RESET; own_addr <= 8'h00; irq_en <= 5'h00;
      flags <= 5'h01; ovf <= 1'b0; tx_hold <= 8'h00; tx_valid <= 1'b0;
      tx_age <= 2'h0; dre_cnt <= 2'h0; irq_o <= 1'b0;
    end else begin
      if (wr_go && aw_addr == `SPTO_OFF_CTRL && s_axi_bvalid_o == 1'b0)
        ctrl <= w_data;
      if (wr_go && aw_addr == `SPTO_OFF_ADDR)
        own_addr <= w_data[7:0];
      if (wr_go && aw_addr == `SPTO_OFF_IRQ_EN)
        irq_en <= w_data[4:0];
      // Clears first, hardware sets below take priority
      if (wr_go && aw_addr == `SPTO_OFF_IRQ_CLR)
        flags <= flags & ~w_data[4:0];
      if (wr_go && aw_addr == `SPTO_OFF_STATUS && w_data[0])
        ovf <= 1'b0;
      // software owns the write; a write into a full register replaces it
      if (wr_data) begin
        tx_hold <= w_data[7:0]; tx_valid <= 1'b1; tx_age <= 2'h0;
        flags[`SPTO_FLG_EMPTY] <= 1'b0; dre_cnt <= 2'h0;
      end else if (tx_valid && do_rise && tx_age != `SPTO_LOAD_MARGIN - 4'h1) begin
        tx_age <= tx_age + 2'h1;
      end
      // loading into shifter empties the register
      if (load_now && !wr_data) begin
        tx_valid <= 1'b0; dre_cnt <= `SPTO_DRE_DELAY;
      end
      // empty flag three bus cycles after emptying
      if (dre_cnt != 2'h0 && !wr_data) begin
        dre_cnt <= dre_cnt - 2'h1;
        if (dre_cnt == 2'h1)
          flags[`SPTO_FLG_EMPTY] <= 1'b1;
      end
      // master done with no further data
      if (is_master && active && char_end && !tx_ready)
        flags[`SPTO_FLG_TX_DONE] <= 1'b1;
      // slave transaction ends on select high
      if (is_slave && ss_high_edge)
        flags[`SPTO_FLG_TX_DONE] <= 1'b1;
      if (rx_cnt != 2'h0 || (char_end && !rx_full))
        flags[`SPTO_FLG_RX_DONE] <= 1'b1;
      else if (rx_cnt == 2'h0)
        flags[`SPTO_FLG_RX_DONE] <= 1'b0;
      if (rd_pop && rx_cnt == 2'h1 && !(char_end && !rx_full))
        flags[`SPTO_FLG_RX_DONE] <= 1'b0;
      // first character compared with own address
      if (is_slave && form == `SPTO_FORM_ADDR && first_char && char_end && rx_char == own_addr)
        flags[`SPTO_FLG_AMATCH] <= 1'b1;
      if (imm_ovf && char_end && rx_full)
        ovf <= 1'b1;
      // marker reached when entry is read
      if (!imm_ovf && rd_pop && head_ovm) begin
        ovf <= 1'b1;
        flags[`SPTO_FLG_ERROR] <= 1'b1;
      end
      if (!en)
        ovf <= 1'b0;
      irq_o <= |(flags & irq_en);
    end
  end

  // Receive buffer
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rx_mem[0] <= 8'h00; rx_mem[1] <= 8'h00; rx_ovm <= 2'h0;
      rx_wp <= 1'b0; rx_rp <= 1'b0; rx_cnt <= 2'h0;
    end else if (!en) begin
      rx_ovm <= 2'h0; rx_wp <= 1'b0; rx_rp <= 1'b0; rx_cnt <= 2'h0;
    end else begin
      if (char_end && !rx_full) begin
        rx_mem[rx_wp] <= rx_char;
        rx_ovm[rx_wp] <= 1'b0;
        rx_wp <= ~rx_wp;
      end
      // full buffer drops the new character; without immediate notification it marks the newest entry
      if (char_end && rx_full && !imm_ovf)
        rx_ovm[~rx_wp] <= 1'b1;
      if (rd_pop)
        rx_rp <= ~rx_rp;
      if ((char_end && !rx_full) && !rd_pop)
        rx_cnt <= rx_cnt + 2'h1;
      else if (!(char_end && !rx_full) && rd_pop)
        rx_cnt <= rx_cnt - 2'h1;
    end
  end

  // Shift engine and pins
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sh_out <= 8'h00; sh_in <= 8'h00; bit_cnt <= 4'h0;
      first_char <= 1'b1; active <= 1'b0; div_cnt <= 4'h0;
      sck_o <= 1'b0; sck_oe_n_o <= 1'b1; ss_n_o <= 1'b1; ss_oe_n_o <= 1'b1;
      mosi_o <= 1'b0; mosi_oe_n_o <= 1'b1; miso_o <= 1'b0; miso_oe_n_o <= 1'b1;
    end else begin
      sck_oe_n_o  <= !is_master;
      mosi_oe_n_o <= !is_master;
      ss_oe_n_o   <= !is_master;
      miso_oe_n_o <= !(is_slave && !ss_st);
      div_cnt <= (sck_run && !m_tick) ? div_cnt + 4'h1 : 4'h0;
      if (is_master && sck_run && m_tick)
        sck_o <= ~sck_o;
      else if (!is_master)
        sck_o <= cpol;
      if (smp) begin
        sh_in <= rx_char;
        bit_cnt <= (bit_cnt == 4'h7) ? 4'h0 : bit_cnt + 4'h1;
      end
      if (shf && bit_cnt != 4'h0)
        sh_out <= {sh_out[6:0], 1'b0};
      if (char_end) begin
        first_char <= 1'b0;
        // late write resends the last received character
        if (!tx_ready)
          sh_out <= rx_char;
      end
      if (load_now)
        sh_out <= tx_hold;
      if (is_master) begin
        if (load_now)
          active <= 1'b1;
        else if (char_end && !tx_ready)
          active <= 1'b0;
        // hardware raises select when auto control is on
        ss_n_o <= auto_ss ? !(sck_run || load_now) : ctrl[`SPTO_CTRL_SS_SW];
      end else begin
        active <= 1'b0;
        ss_n_o <= 1'b1;
      end
      if (is_slave && ss_st) begin
        bit_cnt <= 4'h0;
        first_char <= 1'b1;
      end
      // Next bit goes out on the shift edge itself; the far side's synchroniser eats the slack
      mosi_o <= (load_now && cpha == 1'b0) ? tx_hold[7]
              : (shf && bit_cnt != 4'h0) ? sh_out[6] : sh_out[7];
      miso_o <= (shf && bit_cnt != 4'h0) ? sh_out[6]
              : (shf || (is_slave && ss_st)) ? sh_out[7] : miso_o;
    end
  end
endmodule // spto_top
`default_nettype wire

/* include/spto_consts.vh */
// Constants for the SPI transfer and overflow block
`ifndef SPTO_CONSTS_VH
`define SPTO_CONSTS_VH
`define SPTO_OFF_CTRL      8'h00
`define SPTO_OFF_STATUS    8'h04
`define SPTO_OFF_DATA      8'h08
`define SPTO_OFF_FLAGS     8'h0C
`define SPTO_OFF_IRQ_EN    8'h10
`define SPTO_OFF_IRQ_CLR   8'h14
`define SPTO_OFF_ADDR      8'h18
// Control register fields
`define SPTO_CTRL_ENABLE   0
`define SPTO_CTRL_IMM_OVF  1
`define SPTO_CTRL_AUTO_SS  2
`define SPTO_CTRL_CPHA     3
`define SPTO_CTRL_CPOL     4
`define SPTO_CTRL_MODE_LO  5
`define SPTO_CTRL_FORM_LO  8
`define SPTO_CTRL_SS_SW    12
`define SPTO_CTRL_RESET    32'h0000_0000
`define SPTO_MODE_MASTER   2'h3
`define SPTO_MODE_SLAVE    2'h2
`define SPTO_FORM_ADDR     3'h2
// Flag bit positions (flags, enable and clear registers share them)
`define SPTO_FLG_EMPTY     0
`define SPTO_FLG_TX_DONE   1
`define SPTO_FLG_RX_DONE   2
`define SPTO_FLG_ERROR     3
`define SPTO_FLG_AMATCH    4
`define SPTO_DRE_DELAY     2'h3
`define SPTO_LOAD_MARGIN   4'h3
`define SPTO_MASTER_DIV    4'h4
`endif
